/* verilog/uesbm_core.sv */
// Behaviour
// - usb reset clears control bits three to zero
// - ack of in sets transmit done flag, except a full upload packet
// - transmit toggle flips only after host ack
// - software may write all three toggle bits
// - transmit code: off, stall, nak, valid
// - correct transmission forces transmit code nak
// - endpoint 2 receive code: off, stall, nak, valid
// - correct reception forces receive code nak
// - transfer select: normal, upload, download
// - download: hardware revalidates out, no flag
// - short download packet ends mode, flag, nak
// - upload: in handled by hardware alike
// - receive code locked in download mode
// - transmit code locked in upload mode
// - receive register bits five:four read zero
// - receive toggle flips on matching good packet
// - good out on endpoint 2 sets flag, except a full download packet
// - receive counter decremented by bytes received, reloaded after a full download packet
// - transmit counter gives bytes of next in
module uesbm_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // events from the serial engine
    input wire logic usb_bus_reset,
    input wire logic ep1_in_acked,
    input wire logic ep2_in_acked,
    input wire logic ep2_out_good,
    input wire logic ep2_out_pid_match,
    input wire logic [6:0] ep2_out_bytes,
    // coprocessor buffer side
    input wire logic buf_rx_ready,
    input wire logic buf_tx_ready,
    input wire logic [6:0] buf_tx_bytes,
    // answers to the serial engine
    output logic [1:0] ep1_tx_stat,
    output logic ep1_tx_toggle,
    output logic [1:0] ep2_tx_stat,
    output logic ep2_tx_toggle,
    output logic [6:0] ep2_tx_count,
    output logic [1:0] ep2_rx_stat,
    output logic ep2_rx_toggle,
    output logic [6:0] ep2_rx_count,
    output logic [1:0] ep2_mode,
    output logic bus_reset_active
);

    // ======================================================
    // overview
    // software owns the control bytes and the two counters;
    // the serial engine reports finished transactions as
    // one-cycle pulses and reads back codes, toggles, counts;
    // in the bulk modes the buffer side reopens endpoint 2
    // without software; no packet data passes through here


    // ======================================================
    // state record
    // one record holds every bit of state, so reset and the
    // register stage are a single assignment each
    typedef struct packed {
        logic forced_bus_reset_bit;               // forced bus reset bit
        logic ep1_ctr;            // ep1 transmit done flag
        logic ep1_tog;            // ep1 transmit toggle
        logic [1:0] ep1_stat;     // ep1 transmit code
        logic [1:0] mode;         // ep2 transfer select
        logic rx_ctr;             // ep2 receive done flag
        logic rx_tog;             // ep2 receive toggle
        logic [1:0] rx_stat;      // ep2 receive code
        logic tx_ctr;             // ep2 transmit done flag
        logic tx_tog;             // ep2 transmit toggle
        logic [1:0] tx_stat;      // ep2 transmit code
        logic [6:0] rx_cnt;       // ep2 receive counter
        logic [6:0] rx_max;       // last size written by software
        logic [6:0] tx_cnt;       // ep2 transmit counter
        logic [6:0] tx_max;       // last size written by software
        logic [7:0] rdata;        // read data, one cycle late
    } uesbm_state_t;

    // the max fields keep the size software put in a counter;
    // the bulk modes compare against them to spot the short
    // packet that ends a transfer, and download reloads its
    // counter from them after every full packet

    uesbm_state_t st_reg;   // registered state
    uesbm_state_t st_next;  // next state

    // ======================================================
    // helpers

    // pack flag, toggle and code into a control byte
    // bits five:four always come back as zero
    function automatic logic [7:0] pack_ctl(
        input logic [1:0] hi,
        input logic ctr,
        input logic tog,
        input logic [1:0] stat
    );
        pack_ctl = {hi, 2'b00, ctr, tog, stat};
    endfunction

    // flag update: software clears by writing zero, event wins
    // writing one leaves the flag alone, so a write of other
    // fields cannot drop a flag software has not yet seen
    function automatic logic flag_upd(
        input logic cur,
        input logic wr,
        input logic wbit,
        input logic ev
    );
        flag_upd = (wr ? (cur & wbit) : cur) | ev;
    endfunction

    // ======================================================
    // next-state logic
    // block order is priority: writes, then hardware events,
    // then the usb reset clear; later blocks win a cycle
    always_comb begin
        logic wr_ctl;
        logic wr_ep1;
        logic wr_rx;
        logic wr_rxc;
        logic wr_tx;
        logic wr_txc;
        logic usb_rst;
        logic dl_mode;
        logic ul_mode;
        logic short_rx;
        logic short_tx;
        wr_ctl = 1'b0;
        wr_ep1 = 1'b0;
        wr_rx = 1'b0;
        wr_rxc = 1'b0;
        wr_tx = 1'b0;
        wr_txc = 1'b0;
        // mode and length helpers, worked out below
        usb_rst = 1'b0;
        dl_mode = 1'b0;
        ul_mode = 1'b0;
        short_rx = 1'b0;
        short_tx = 1'b0;

        // hold state; read data lasts one cycle only
        st_next = st_reg;
        st_next.rdata = 8'h00;

        // write address decode
        // one register per cycle; unmapped writes are dropped
        if (reg_wr && reg_addr == uesbm_pkg::OFS_USB_CTRL) begin
            wr_ctl = 1'b1;
        end else if (reg_wr && reg_addr == uesbm_pkg::OFS_EP1_TX) begin
            wr_ep1 = 1'b1;
        end else if (reg_wr && reg_addr == uesbm_pkg::OFS_EP2_RX) begin
            wr_rx = 1'b1;
        end else if (reg_wr &&
                     reg_addr == uesbm_pkg::OFS_EP2_RX_CNT) begin
            wr_rxc = 1'b1;
        end else if (reg_wr && reg_addr == uesbm_pkg::OFS_EP2_TX) begin
            wr_tx = 1'b1;
        end else if (reg_wr &&
                     reg_addr == uesbm_pkg::OFS_EP2_TX_CNT) begin
            wr_txc = 1'b1;
        end

        // read address decode, unmapped reads give zero
        // the byte shows on the port in the next cycle only
        if (reg_rd && reg_addr == uesbm_pkg::OFS_USB_CTRL) begin
            // only the forced reset bit lives in this block
            st_next.rdata = {7'h00, st_reg.forced_bus_reset_bit};
        end else if (reg_rd && reg_addr == uesbm_pkg::OFS_EP1_TX) begin
            st_next.rdata = pack_ctl(2'b00, st_reg.ep1_ctr,
                                     st_reg.ep1_tog, st_reg.ep1_stat);
        end else if (reg_rd && reg_addr == uesbm_pkg::OFS_EP2_RX) begin
            // bits five:four are packed as zero
            st_next.rdata = pack_ctl(st_reg.mode, st_reg.rx_ctr,
                                     st_reg.rx_tog, st_reg.rx_stat);
        end else if (reg_rd &&
                     reg_addr == uesbm_pkg::OFS_EP2_RX_CNT) begin
            // counters are seven bits, bit seven reads zero
            st_next.rdata = {1'b0, st_reg.rx_cnt};
        end else if (reg_rd && reg_addr == uesbm_pkg::OFS_EP2_TX) begin
            // transmit bytes carry no select field
            st_next.rdata = pack_ctl(2'b00, st_reg.tx_ctr,
                                     st_reg.tx_tog, st_reg.tx_stat);
        end else if (reg_rd &&
                     reg_addr == uesbm_pkg::OFS_EP2_TX_CNT) begin
            st_next.rdata = {1'b0, st_reg.tx_cnt};
        end


        // tests use the held state: a mode write acts next cycle
        // a packet is short below the programmed size
        dl_mode = (st_reg.mode == uesbm_pkg::MD_DOWNLOAD);
        ul_mode = (st_reg.mode == uesbm_pkg::MD_UPLOAD);
        short_rx = (ep2_out_bytes < st_reg.rx_max);
        short_tx = (st_reg.tx_cnt < st_reg.tx_max);

        // forced reset bit
        // a level: the reset clear repeats while it stays set
        if (wr_ctl) begin
            st_next.forced_bus_reset_bit = reg_wdata[uesbm_pkg::POS_FORCED_BUS_RESET_BIT];
        end

        // ----- endpoint 1 transmission -----
        // a host ack below beats a write in the same cycle
        if (wr_ep1) begin
            st_next.ep1_tog = reg_wdata[uesbm_pkg::POS_TOG];
            st_next.ep1_stat = reg_wdata[1:0];
        end
        st_next.ep1_ctr = flag_upd(st_reg.ep1_ctr, wr_ep1,
                                   reg_wdata[uesbm_pkg::POS_CTR],
                                   ep1_in_acked);
        if (ep1_in_acked) begin
            // ack from host moves to the other data pid
            st_next.ep1_tog = ~st_reg.ep1_tog;
            st_next.ep1_stat = uesbm_pkg::ST_NAK;
        end

        // ----- endpoint 2 reception register -----
        // the select is always writable; only the code locks,
        // judged on the mode held before this write
        if (wr_rx) begin
            st_next.mode = reg_wdata[uesbm_pkg::POS_MODE_LO +: 2];
            st_next.rx_tog = reg_wdata[uesbm_pkg::POS_TOG];
            // code is locked while download runs
            if (!dl_mode) begin
                st_next.rx_stat = reg_wdata[1:0];
            end
        end
        if (wr_rxc) begin
            // software loads the allocated size
            // kept as the download short-packet limit
            st_next.rx_cnt = reg_wdata[6:0];
            st_next.rx_max = reg_wdata[6:0];
        end

        // ----- endpoint 2 transmission register -----
        // in upload only hardware moves the code
        if (wr_tx) begin
            st_next.tx_tog = reg_wdata[uesbm_pkg::POS_TOG];
            // code is locked while upload runs
            if (!ul_mode) begin
                st_next.tx_stat = reg_wdata[1:0];
            end
        end
        if (wr_txc) begin
            // software loads the bytes for the next in
            // and the size that marks a short upload packet
            st_next.tx_cnt = reg_wdata[6:0];
            st_next.tx_max = reg_wdata[6:0];
        end

        // ----- endpoint 2 good out packet -----
        // toggle follows the pid match, counter drops by the
        // bytes taken, code parks on nak until reopened
        if (ep2_out_good) begin
            // a repeated packet keeps the expected pid
            if (ep2_out_pid_match) begin
                st_next.rx_tog = ~st_reg.rx_tog;
            end
            // remaining space after the packet
            st_next.rx_cnt = 7'(st_reg.rx_cnt - ep2_out_bytes);
            st_next.rx_stat = uesbm_pkg::ST_NAK;
            if (dl_mode && short_rx) begin
                // short packet closes the bulk download
                st_next.mode = uesbm_pkg::MD_NORMAL;
            end else if (dl_mode) begin
                // full packet: counter rearmed for the next one
                st_next.rx_cnt = st_reg.rx_max;
            end
        end
        // a full download packet raises no flag
        st_next.rx_ctr = flag_upd(st_reg.rx_ctr, wr_rx,
                                  reg_wdata[uesbm_pkg::POS_CTR],
                                  ep2_out_good &&
                                  (!dl_mode || short_rx));


        // download: reopen the endpoint once the buffer has room
        // skipped in a packet cycle so its nak is not lost
        if (dl_mode && !ep2_out_good && buf_rx_ready &&
            st_reg.rx_stat == uesbm_pkg::ST_NAK) begin
            st_next.rx_stat = uesbm_pkg::ST_VALID;
        end


        // ----- endpoint 2 acknowledged in packet -----
        // in upload a packet below the size ends the transfer
        if (ep2_in_acked) begin
            st_next.tx_tog = ~st_reg.tx_tog;
            st_next.tx_stat = uesbm_pkg::ST_NAK;
            if (ul_mode && short_tx) begin
                // short packet closes the bulk upload
                st_next.mode = uesbm_pkg::MD_NORMAL;
            end
        end
        // full upload packets stay silent, as in download
        st_next.tx_ctr = flag_upd(st_reg.tx_ctr, wr_tx,
                                  reg_wdata[uesbm_pkg::POS_CTR],
                                  ep2_in_acked &&
                                  (!ul_mode || short_tx));


        // upload: take the next packet size from the buffer
        // size and code move together, so no stale size is sent
        if (ul_mode && !ep2_in_acked && buf_tx_ready &&
            st_reg.tx_stat == uesbm_pkg::ST_NAK) begin
            st_next.tx_cnt = buf_tx_bytes;
            st_next.tx_stat = uesbm_pkg::ST_VALID;
        end


        // ----- usb reset, from the bus or forced -----
        // last, so it beats every write and event above;
        // counters, sizes, select and forced bit are kept
        usb_rst = usb_bus_reset | st_reg.forced_bus_reset_bit;
        if (usb_rst) begin
            // toggles restart on data0, codes on disabled
            st_next.ep1_ctr = 1'b0;
            st_next.ep1_tog = 1'b0;
            st_next.ep1_stat = uesbm_pkg::ST_DISABLED;
            st_next.rx_ctr = 1'b0;
            st_next.rx_tog = 1'b0;
            st_next.rx_stat = uesbm_pkg::ST_DISABLED;
            st_next.tx_ctr = 1'b0;
            st_next.tx_tog = 1'b0;
            st_next.tx_stat = uesbm_pkg::ST_DISABLED;
        end
    end

    // ======================================================
    // state register
    // synchronous reset: all fields zero, the reset byte
    // of every register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            // every field takes its computed next value
            st_reg <= st_next;
        end
    end

    // ======================================================
    // outputs
    // all from the state record except the reset indication,
    // which follows the bus reset input in the same cycle
    assign reg_rdata = st_reg.rdata;
    assign ep1_tx_stat = st_reg.ep1_stat;
    assign ep1_tx_toggle = st_reg.ep1_tog;
    assign ep2_tx_stat = st_reg.tx_stat;
    assign ep2_tx_toggle = st_reg.tx_tog;
    assign ep2_tx_count = st_reg.tx_cnt;
    assign ep2_rx_stat = st_reg.rx_stat;
    assign ep2_rx_toggle = st_reg.rx_tog;
    assign ep2_rx_count = st_reg.rx_cnt;
    assign ep2_mode = st_reg.mode;
    assign bus_reset_active = usb_bus_reset | st_reg.forced_bus_reset_bit;

endmodule

/* verilog/uesbm_pkg.sv */
// ==========================================================
// endpoint status and bulk mode constants
package uesbm_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_USB_CTRL = 8'h32;
    localparam logic [7:0] OFS_EP1_TX = 8'h3a;
    localparam logic [7:0] OFS_EP2_RX = 8'h3c;
    localparam logic [7:0] OFS_EP2_RX_CNT = 8'h3d;
    localparam logic [7:0] OFS_EP2_TX = 8'h3e;
    localparam logic [7:0] OFS_EP2_TX_CNT = 8'h3f;

    // field positions inside the control registers
    localparam int POS_MODE_LO = 6;
    localparam int POS_CTR = 3;
    localparam int POS_TOG = 2;
    localparam int POS_STAT_LO = 0;
    localparam int POS_FORCED_BUS_RESET_BIT = 0;

    // field widths and reset values
    localparam int CNT_W = 7;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [6:0] RST_CNT = 7'h00;

    // handshake response codes
    typedef enum logic [1:0] {
        ST_DISABLED = 2'b00,
        ST_STALL = 2'b01,
        ST_NAK = 2'b10,
        ST_VALID = 2'b11
    } uesbm_stat_t;

    // endpoint 2 transfer modes
    typedef enum logic [1:0] {
        MD_NORMAL = 2'b00,
        MD_UPLOAD = 2'b01,
        MD_DOWNLOAD = 2'b10,
        MD_SPARE = 2'b11
    } uesbm_mode_t;

endpackage

/* dv/uesbm_sva.sv */
// ==========================================================
// port checker for the endpoint status block
module uesbm_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // engine events and buffer
    input wire logic ep1_in_acked,
    input wire logic ep2_in_acked,
    input wire logic ep2_out_good,
    input wire logic ep2_out_pid_match,
    input wire logic [6:0] ep2_out_bytes,
    input wire logic buf_rx_ready,
    input wire logic buf_tx_ready,
    input wire logic [6:0] buf_tx_bytes,
    // answers
    input wire logic [1:0] ep1_tx_stat,
    input wire logic ep1_tx_toggle,
    input wire logic [1:0] ep2_tx_stat,
    input wire logic ep2_tx_toggle,
    input wire logic [6:0] ep2_tx_count,
    input wire logic [1:0] ep2_rx_stat,
    input wire logic ep2_rx_toggle,
    input wire logic [6:0] ep2_rx_count,
    input wire logic [1:0] ep2_mode,
    input wire logic bus_reset_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // write data of the last cycle, for the mode field
    logic [7:0] wd_q;
    // hardware events count only outside a usb reset
    wire hw = !bus_reset_active;
    always_ff @(posedge ref_clk) wd_q <= reg_wdata;
    a_usb_rst_clear: assert property (
        bus_reset_active |=> ep1_tx_stat == 2'b00 && !ep1_tx_toggle &&
        ep2_tx_stat == 2'b00 && ep2_rx_stat == 2'b00 && !ep2_rx_toggle)
        else $error("usb reset left control bits set");
    a_ep1_ack_nak: assert property (
        ep1_in_acked && hw |=> ep1_tx_stat == 2'b10 &&
        ep1_tx_toggle != $past(ep1_tx_toggle))
        else $error("ep1 ack did not nak and flip");
    a_ep2_ack_nak: assert property (
        ep2_in_acked && hw |=> ep2_tx_stat == 2'b10 &&
        ep2_tx_toggle != $past(ep2_tx_toggle))
        else $error("ep2 ack did not nak and flip");
    a_out_nak: assert property (
        ep2_out_good && hw && ep2_mode == 2'b00 |=> ep2_rx_stat == 2'b10)
        else $error("normal out left receive code");
    a_rx_toggle: assert property (
        ep2_out_good && hw |=> ep2_rx_toggle ==
        ($past(ep2_rx_toggle) ^ $past(ep2_out_pid_match)))
        else $error("receive toggle wrong");
    a_rx_count: assert property (
        ep2_out_good && hw && ep2_mode == 2'b00 |=> ep2_rx_count ==
        7'($past(ep2_rx_count) - $past(ep2_out_bytes)))
        else $error("receive count not decremented");
    a_rx_lock: assert property (
        reg_wr && reg_addr == uesbm_pkg::OFS_EP2_RX && ep2_mode == 2'b10
        && hw && !ep2_out_good && !buf_rx_ready |=> $stable(ep2_rx_stat))
        else $error("receive code written in download");
    a_tx_lock: assert property (
        reg_wr && reg_addr == uesbm_pkg::OFS_EP2_TX && ep2_mode == 2'b01
        && hw && !ep2_in_acked && !buf_tx_ready |=> $stable(ep2_tx_stat))
        else $error("transmit code written in upload");
    a_rsvd_zero: assert property (
        reg_rd && reg_addr == uesbm_pkg::OFS_EP2_RX |=>
        reg_rdata[5:4] == 2'b00)
        else $error("reserved receive bits not zero");
    a_mode_write: assert property (
        reg_wr && reg_addr == uesbm_pkg::OFS_EP2_RX && !ep2_out_good &&
        !ep2_in_acked |=> ep2_mode == wd_q[7:6])
        else $error("transfer select not written");
    a_upload_load: assert property (
        buf_tx_ready && ep2_mode == 2'b01 && ep2_tx_stat == 2'b10 && hw &&
        !ep2_in_acked |=> ep2_tx_count == $past(buf_tx_bytes) &&
        ep2_tx_stat == 2'b11)
        else $error("upload did not load the counter");
    // main scenarios
    cover property (ep2_mode == 2'b10 ##1 ep2_mode == 2'b00);
    cover property (ep2_mode == 2'b01 && ep2_in_acked);
    cover property (bus_reset_active);
endmodule

bind uesbm_core uesbm_sva uesbm_sva_inst (.*);

/* dv/uesbm_host.sv */
// ==========================================================
// host side: turns bench requests into engine event pulses
module uesbm_host (
    // clock
    input wire logic ref_clk,
    // bench requests
    input wire logic req_go,
    input wire logic [1:0] req_kind,
    input wire logic [6:0] req_bytes,
    input wire logic req_match,
    // events towards the block
    output logic ep1_in_acked,
    output logic ep2_in_acked,
    output logic ep2_out_good,
    output logic ep2_out_pid_match,
    output logic [6:0] ep2_out_bytes
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ep1_in_acked, ep2_in_acked, ep2_out_good} = 3'b000;
    initial {ep2_out_pid_match, ep2_out_bytes} = 8'h55;
    // one pulse per request; qualifiers scramble outside a packet
    always @(posedge ref_clk) begin
        ep1_in_acked <= req_go && req_kind == 2'd1;
        ep2_in_acked <= req_go && req_kind == 2'd2;
        ep2_out_good <= req_go && req_kind == 2'd3;
        ep2_out_pid_match <= req_go ? req_match : ~ep2_out_pid_match;
        ep2_out_bytes <= req_go ? req_bytes : ~ep2_out_bytes;
    end
endmodule

/* dv/tb.sv */
// ==========================================================
// self-checking bench for the endpoint status block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, reg_wr, reg_rd, usb_bus_reset, t, m, rxt;
    logic buf_rx_ready, buf_tx_ready, req_go, req_match;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] buf_tx_bytes, req_bytes, cnt, b;
    logic [1:0] req_kind, ep1_tx_stat, ep2_tx_stat, ep2_rx_stat, ep2_mode;
    logic ep1_in_acked, ep2_in_acked, ep2_out_good, ep2_out_pid_match;
    logic [6:0] ep2_out_bytes, ep2_tx_count, ep2_rx_count;
    logic ep1_tx_toggle, ep2_tx_toggle, ep2_rx_toggle, bus_reset_active;
    // ep1 tx, ep2 tx, ep2 rx, rx count, tx count, usb control
    logic [7:0] ad [6] = '{uesbm_pkg::OFS_EP1_TX, uesbm_pkg::OFS_EP2_TX,
        uesbm_pkg::OFS_EP2_RX, uesbm_pkg::OFS_EP2_RX_CNT,
        uesbm_pkg::OFS_EP2_TX_CNT, uesbm_pkg::OFS_USB_CTRL};
    int error_cnt = 0, checked = 0, cyc = 0, seed = 32'hbd6cbdaa;
    uesbm_core uesbm_core_inst (.*);
    uesbm_host uesbm_host_inst (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // expectation, compare and bus tasks
    function automatic logic [7:0] ctl(logic [1:0] md, logic f, logic tg,
        logic [1:0] cd);
        return {md, 2'b00, f, tg, cd};
    endfunction
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 1'b0;
        @(negedge ref_clk) chk("reg_rdata", reg_rdata, e);
    endtask
    // host packet: 1 ep1 ack, 2 ep2 ack, 3 ep2 out data
    task automatic ev(logic [1:0] k, logic [6:0] n, logic mt);
        @(posedge ref_clk) {req_go, req_kind, req_bytes, req_match} <=
            {1'b1, k, n, mt};
        @(posedge ref_clk) req_go <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic give_verdict();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {sys_rst, reg_wr, reg_rd, usb_bus_reset, req_go, req_match} = 6'h20;
        {reg_addr, reg_wdata, buf_tx_bytes, req_bytes, req_kind} = '0;
        {buf_rx_ready, buf_tx_ready} = 2'b00;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 3; i++) rd(ad[i], 8'h00);
        // every transmit code with a random toggle, then an acked packet
        for (int i = 0; i < 2; i++) begin
            for (int c = 0; c < 4; c++) begin
                t = 1'($random(seed));
                wr(ad[i], ctl(2'b00, 1'b0, t, c[1:0]));
                rd(ad[i], ctl(2'b00, 1'b0, t, c[1:0]));
            end
            ev(2'(i + 1), 7'h00, 1'b0);
            rd(ad[i], ctl(2'b00, 1'b1, ~t, 2'b10));
        end
        // reserved bits, then random packets in normal operation
        wr(ad[2], 8'h33);
        rd(ad[2], 8'h03);
        {rxt, cnt} = 8'h7f;
        wr(ad[3], {1'b0, cnt});
        for (int k = 0; k < 5; k++) begin
            b = 7'($random(seed)) & 7'h0f;
            m = 1'($random(seed));
            wr(ad[2], ctl(2'b00, 1'b0, rxt, 2'b11));
            ev(2'd3, b, m);
            rxt ^= m;
            cnt -= b;
            rd(ad[2], ctl(2'b00, 1'b1, rxt, 2'b10));
            rd(ad[3], {1'b0, cnt});
        end
        // download: full packet, locked code, refill, short packet
        wr(ad[3], 8'h40);
        wr(ad[2], ctl(2'b00, 1'b0, rxt, 2'b11));
        wr(ad[2], ctl(2'b10, 1'b0, rxt, 2'b11));
        ev(2'd3, 7'h40, 1'b1);
        rxt = ~rxt;
        rd(ad[2], ctl(2'b10, 1'b0, rxt, 2'b10));
        wr(ad[2], ctl(2'b10, 1'b0, rxt, 2'b01));
        chk("rx_stat", {6'h0, ep2_rx_stat}, 8'h02);
        @(posedge ref_clk) buf_rx_ready <= 1'b1;
        @(posedge ref_clk) buf_rx_ready <= 1'b0;
        @(negedge ref_clk) chk("rx_stat", {6'h0, ep2_rx_stat}, 8'h03);
        ev(2'd3, 7'h0a, 1'b1);
        rxt = ~rxt;
        rd(ad[2], ctl(2'b00, 1'b1, rxt, 2'b10));
        rd(ad[3], 8'h36);
        // upload: buffer loads counter, locked code, short ack ends it
        wr(ad[4], 8'h40);
        wr(ad[1], 8'h02);
        wr(ad[2], ctl(2'b01, 1'b0, rxt, 2'b10));
        @(posedge ref_clk) {buf_tx_ready, buf_tx_bytes} <= 8'h94;
        @(posedge ref_clk) {buf_tx_ready, buf_tx_bytes} <= 8'h6b;
        @(negedge ref_clk) chk("tx_count", {1'b0, ep2_tx_count}, 8'h14);
        wr(ad[1], 8'h01);
        chk("tx_stat", {6'h0, ep2_tx_stat}, 8'h03);
        ev(2'd2, 7'h00, 1'b0);
        rd(ad[1], 8'h0e);
        chk("mode", {6'h0, ep2_mode}, 8'h00);
        // forced and bus resets clear low bits, counters stay
        wr(ad[5], 8'h01);
        chk("reset_act", {7'h0, bus_reset_active}, 8'h01);
        @(negedge ref_clk);
        chk("ep1_stat", {6'h0, ep1_tx_stat}, 8'h00);
        rd(ad[3], 8'h36);
        wr(ad[5], 8'h00);
        chk("reset_act", {7'h0, bus_reset_active}, 8'h00);
        wr(ad[0], 8'h07);
        @(posedge ref_clk) usb_bus_reset <= 1'b1;
        @(posedge ref_clk) usb_bus_reset <= 1'b0;
        rd(ad[0], 8'h00);
        rd(ad[2], 8'h00);
        // unmapped place
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00);
        give_verdict();
    end
endmodule
